// *** core/icd_map.vh ***
`ifndef ICD_MAP_VH
`define ICD_MAP_VH
`define ICD_DEV_ADDR 7'h48
`define ICD_MEM_ZERO 8'hF8
`define ICD_MEM_ONE 8'hF9
`define ICD_SIGN_BIT 7
`define ICD_MAG_MSB 3
`define ICD_REG_RESET 8'h00
`define ICD_BITS_PER_BYTE 4'h8
`endif

// *** core/icd_sync.v ***
`timescale 1ns/1ns
// Two-flop synchroniser per bit
module icd_sync #(
   parameter WIDTH = 2
) (
   input wire i_clock,
   input wire i_reset,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         always @(posedge i_clock or posedge i_reset) begin
            if (i_reset) begin
               meta_q[g] <= 1'b1;
               sync_q[g] <= 1'b1;
            end else begin
               meta_q[g] <= i_async[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate
   assign o_sync = sync_q;
endmodule // icd_sync

// *** core/icd_slave.v ***
// Overview of operation
// - Each byte is followed by a ninth acknowledge slot.
// - Receiver pulls data low in ninth slot to acknowledge.
// - Receiver leaves data high in ninth slot to not-acknowledge.
// - Acknowledge bit changes while clock low, sampled on rising edge.
// - Not-acknowledge ends a read or refuses data.
// - Write bytes arrive MSB first; slave returns one acknowledge.
// - Read bytes leave MSB first; master acks to continue.
// - After master nack on read, slave releases data line.
// - First byte after start is seven-bit address plus direction.
// - Respond to 90h as write, 91h as read.
// - Address mismatch: stay off bus until next start.
// - Second write byte selects the target register.
// - F8 selects output zero control, F9 output one control.
// - Top bit sign, low four bits magnitude; zero means off.
// - Both control registers reset to zero.
// - Capture on clock rise, change output after clock fall.
`timescale 1ns/1ns
`include "icd_map.vh"
module icd_slave (
   input wire i_clock,
   input wire i_reset,
   input wire i_scl,
   input wire i_sda,
   output reg o_sda_out,
   output reg o_sda_oe,
   output reg o_current_output_zero_source,
   output reg [3:0] o_current_output_zero_magnitude,
   output reg o_current_output_one_source,
   output reg [3:0] o_current_output_one_magnitude,
   output reg o_busy
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_MEM = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_READ = 3'h4;
   localparam ST_IGNORE = 3'h5;

   wire [1:0] sync_w;
   wire scl_s;
   wire sda_s;
   reg scl_q;
   reg sda_q;
   reg [2:0] state_q;
   reg [3:0] bit_q;
   reg [7:0] shift_q;
   reg ack_q;
   reg [7:0] mem_q;
   reg [7:0] reg0_q;
   reg [7:0] reg1_q;
   reg [7:0] tx_q;
   reg drive_q;
   reg nack_q;
   reg hit_zero;
   reg hit_one;

   icd_sync #(.WIDTH(2)) u_sync (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_async({i_scl, i_sda}),
      .o_sync(sync_w)
   );
   assign scl_s = sync_w[1];
   assign sda_s = sync_w[0];

   // Decode of the stored memory address
   always @* begin
      hit_zero = 1'b0;
      hit_one = 1'b0;
      case (mem_q)
         `ICD_MEM_ZERO: begin
            hit_zero = 1'b1;
         end
         `ICD_MEM_ONE: begin
            hit_one = 1'b1;
         end
         default: begin
            hit_zero = 1'b0;
         end
      endcase
   end

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_w = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_w = scl_s & scl_q & ~sda_q & sda_s;
   wire [7:0] byte_w = {shift_q[6:0], sda_s};
   wire [7:0] sel_w = hit_one ? reg1_q : reg0_q;
   wire addr_hit_w = (shift_q[7:1] == `ICD_DEV_ADDR);
   // Read bits leave MSB first
   wire [2:0] tx_idx_w = 3'h7 - bit_q[2:0];


   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         ack_q <= 1'b0;
         mem_q <= `ICD_MEM_ZERO;
         reg0_q <= `ICD_REG_RESET;
         reg1_q <= `ICD_REG_RESET;
         tx_q <= 8'h00;
         drive_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         if (start_w) begin
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            drive_q <= 1'b0;
         end else if (stop_w) begin
            state_q <= ST_IDLE;
            drive_q <= 1'b0;
         end else if (scl_rise) begin
            if (ack_q) begin
               // Ninth slot sampled
               if (state_q == ST_READ) begin
                  nack_q <= sda_s;
                  tx_q <= sel_w;
               end
            end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
               shift_q <= byte_w;
               bit_q <= bit_q + 4'h1;
            end
         end else if (scl_fall) begin
            if (ack_q) begin
               ack_q <= 1'b0;
               bit_q <= 4'h0;
               drive_q <= 1'b0;
               if (state_q == ST_READ) begin
                  if (nack_q) begin
                     state_q <= ST_IGNORE;
                  end else begin
                     drive_q <= 1'b1;
                  end
               end
            end else if (bit_q == `ICD_BITS_PER_BYTE) begin
               ack_q <= 1'b1;
               case (state_q)
                  ST_ADDR: begin
                     if (addr_hit_w) begin
                        drive_q <= 1'b1;
                        if (shift_q[0]) begin
                           state_q <= ST_READ;
                           tx_q <= sel_w;
                        end else begin
                           state_q <= ST_MEM;
                        end
                     end else begin
                        state_q <= ST_IGNORE;
                     end
                  end
                  ST_MEM: begin
                     mem_q <= shift_q;
                     drive_q <= 1'b1;
                     state_q <= ST_DATA;
                  end
                  ST_DATA: begin
                     if (hit_zero) begin
                        reg0_q <= shift_q;
                     end
                     if (hit_one) begin
                        reg1_q <= shift_q;
                     end
                     drive_q <= 1'b1;
                  end
                  ST_READ: begin
                     drive_q <= 1'b0;
                  end
                  default: begin
                     drive_q <= 1'b0;
                  end
               endcase
            end else if (state_q == ST_READ) begin
               drive_q <= ~tx_q[tx_idx_w];
            end
         end
         // Read path: first data bit driven on the falling edge ending ack
         if (scl_fall && ack_q && state_q == ST_READ && !nack_q) begin
            drive_q <= ~sel_w[`ICD_SIGN_BIT];
            tx_q <= sel_w;
         end
      end
   end

   // Output flops, one clock behind the internal state
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
         o_current_output_zero_source <= 1'b0;
         o_current_output_zero_magnitude <= 4'h0;
         o_current_output_one_source <= 1'b0;
         o_current_output_one_magnitude <= 4'h0;
         o_busy <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
         o_sda_oe <= drive_q;
         o_current_output_zero_source <= reg0_q[`ICD_SIGN_BIT];
         o_current_output_zero_magnitude <= reg0_q[`ICD_MAG_MSB:0];
         o_current_output_one_source <= reg1_q[`ICD_SIGN_BIT];
         o_current_output_one_magnitude <= reg1_q[`ICD_MAG_MSB:0];
         o_busy <= (state_q != ST_IDLE) && (state_q != ST_IGNORE);
      end
   end
endmodule // icd_slave

// *** dv/icd_master.sv ***
`timescale 1ns/1ns
module icd_master(
   input wire i_clock,
   output logic scl,
   output logic sda_lo,
   input wire sda
);
   initial {scl, sda_lo} = 2'b10;
   task wt(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   task start;
      wt(3);
      sda_lo <= 1'b1;
      wt(3);
      scl <= 1'b0;
   endtask
   task stop;
      wt(3);
      sda_lo <= 1'b1;
      wt(2);
      scl <= 1'b1;
      wt(3);
      sda_lo <= 1'b0;
      wt(2);
   endtask
   // Ten clocks per bit: 80 ns
   task bitx(input logic b, output logic r);
      wt(3);
      sda_lo <= !b;
      wt(2);
      scl <= 1'b1;
      wt(3);
      r = sda;
      wt(2);
      scl <= 1'b0;
   endtask
   task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
      for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
      bitx(a, k);
   endtask
endmodule // icd_master

// *** dv/icd_slave_checker.sv ***
`timescale 1ns/1ns
module icd_slave_checker(
   input wire i_clock, i_reset, i_scl, i_sda, o_sda_out, o_sda_oe, o_busy,
   input wire o_current_output_zero_source, o_current_output_one_source,
   input wire [3:0] o_current_output_zero_magnitude, o_current_output_one_magnitude
);
   wire [4:0] c0 = {o_current_output_zero_source, o_current_output_zero_magnitude};
   wire [4:0] c1 = {o_current_output_one_source, o_current_output_one_magnitude};
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   open_drain_a: assert property (!o_sda_out) else $error("sda high");
   reset_clear_a: assert property (disable iff (1'b0) i_reset |-> !(c0 || c1 || o_sda_oe))
      else $error("reset state");
   sda_change_a: assert property ($changed(o_sda_oe) |-> !i_scl) else $error("sda edge");
   ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8]) else $error("ack short");
   off_bus_a: assert property (o_sda_oe |-> o_busy) else $error("drive idle");
   zero_edge_a: assert property ($changed(c0) |-> !i_scl) else $error("zero edge");
   one_edge_a: assert property ($changed(c1) |-> !i_scl) else $error("one edge");
   out_busy_a: assert property ($changed({c0, c1}) |-> o_busy) else $error("out idle");
endmodule // icd_slave_checker
bind icd_slave icd_slave_checker u_icd_slave_checker(.*);

// *** dv/icd_slave_bench.sv ***
`timescale 1ns/1ns
module icd_slave_bench;
   logic i_clock = 1'b0, i_reset = 1'b0, k;
   logic [31:0] rs = 32'h6D88E82D;
   logic [7:0] r0 = 8'h00, r1 = 8'h00, ma = 8'hF8, g;
   wire scl, mlo, oe, s0, s1, bz;
   wire [3:0] m0, m1;
   wire sda = !(mlo | oe);
   int bad_count = 0, tests_run = 0;
   initial forever #4 i_clock = !i_clock;
   icd_master u_icd_master(.i_clock(i_clock), .scl(scl), .sda_lo(mlo), .sda(sda));
   icd_slave u_icd_slave(.i_clock(i_clock), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
      .o_sda_out(), .o_sda_oe(oe), .o_current_output_zero_source(s0),
      .o_current_output_zero_magnitude(m0), .o_current_output_one_source(s1),
      .o_current_output_one_magnitude(m1), .o_busy(bz));
   function logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %h %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task sb(input logic [7:0] d, input logic ok);
      u_icd_master.xfer(d, 1'b1, g, k);
      chk({7'h00, k}, {7'h00, !ok});
   endtask
   task wr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
      u_icd_master.start;
      sb(a, a == 8'h90);
      sb(m, a == 8'h90);
      sb(d, a == 8'h90);
      u_icd_master.stop;
      if (a == 8'h90) begin
         ma = m;
         r0 = m == 8'hF8 ? d & 8'h8F : r0;
         r1 = m == 8'hF9 ? d & 8'h8F : r1;
      end
      repeat (4) @(posedge i_clock);
      chk({s0, 3'h0, m0}, r0);
      chk({s1, 3'h0, m1}, r1);
      chk({7'h00, bz}, 8'h00);
   endtask
   task rd(input logic [7:0] a);
      u_icd_master.start;
      sb(a, a == 8'h91);
      u_icd_master.xfer(8'hFF, 1'b1, g, k);
      chk(g & 8'h8F, a != 8'h91 ? 8'h8F : ma == 8'hF9 ? r1 : r0);
      u_icd_master.stop;
   endtask
   initial begin
      i_reset <= 1'b1;
      repeat (5) @(posedge i_clock);
      i_reset <= 1'b0;
      repeat (5) @(posedge i_clock);
      rd(8'h91);
      wr(8'h92, 8'hF8, 8'h8A);
      rd(8'h93);
      wr(8'h90, 8'hF7, 8'h55);
      repeat (30) begin
         rs = nx(rs);
         wr(8'h90, rs[9] ? {7'h7C, rs[8]} : rs[23:16], rs[7:0]);
         rd(8'h91);
      end
      report_and_stop;
   end
endmodule // icd_slave_bench
